// [common/strap_cfg_pkg.sv]
package strap_cfg_pkg;
   // Strap geometry
   localparam int unsigned NUM_PINS = 8;
   localparam int unsigned BITS_PER_PIN = 4;
   // Strap pin indices
   localparam int unsigned PIN_SPEED = 7;
   localparam int unsigned PIN_MAC = 6;
   localparam int unsigned PIN_CLK = 5;
   localparam int unsigned PIN_LEDRATE = 4;
   localparam int unsigned PIN_LED3 = 3;
   localparam int unsigned PIN_ADDR_REV = 2;
   localparam int unsigned PIN_ADDR4 = 1;
   localparam int unsigned PIN_ADDR3 = 0;
   // Bit positions within a strap pin nibble
   localparam int unsigned BIT_MSB = 3;
   localparam int unsigned BIT_MID = 2;
   localparam int unsigned BIT_ONE = 1;
   localparam int unsigned BIT_LSB = 0;
   // LED pins and the width of each indication function
   localparam int unsigned NUM_LEDS = 4;
   localparam int unsigned LED_FUNC_BITS = 2;
   // Loaded image before any strap capture
   localparam logic [31:0] IMAGE_RESET = 32'h0000_0000;
   // Media interface codes
   localparam logic [2:0] MEDIA_COPPER = 3'h0;
   localparam logic [2:0] MEDIA_PASSTHRU = 3'h1;
   localparam logic [2:0] MEDIA_FIBER = 3'h2;
   localparam logic [2:0] MEDIA_AMS_PASS = 3'h5;
   localparam logic [2:0] MEDIA_AMS_FIBER = 3'h6;
   // Speed and duplex advertisement encodings: {reg4[8:5], reg9[9:8]}
   localparam logic [3:0] ADV4_ALL = 4'hF;
   localparam logic [1:0] ADV9_ALL = 2'h3;
   localparam logic [3:0] ADV4_FDX_HDX100 = 4'hF;
   localparam logic [1:0] ADV9_FDX = 2'h2;
   localparam logic [3:0] ADV4_NONE = 4'h0;
   localparam logic [1:0] ADV9_NONE = 2'h0;
   // Load sequencing
   localparam logic [1:0] LOAD_CYCLES = 2'h2;
   typedef enum logic [1:0] {ST_RESET, ST_SETTLE, ST_LOADED} load_state_t;
endpackage

// [dv/strap_board.sv]
`timescale 1ns/100ps
module strap_board (input wire logic [31:0] setting_i, output logic [31:0] pins_o);
   // Reserved top bit of pin 7 always strapped low
   assign pins_o = {1'b0, setting_i[30:0]};
endmodule

// [dv/tb.sv]
`timescale 1ns/100ps
module tb;
   logic MCLK_I = 0, RESET_I = 1, SW_WRITE_I = 0, LOADED_O, DOWNSHIFT_EN_O, MAC_ANEG_EN_O;
   logic LINK_POWER_SAVING_MODE_O, ADV_ASYM_PAUSE_O, ADV_SYM_PAUSE_O, MEDIA_RESERVED_O;
   logic SIGNAL_DETECT_INPUT_POL_O, REF_CLK_156_O, REFERENCE_CLOCK_OUTPUT_EN_O;
   logic LED_FIBER_COMBINE_O, ADDR_REVERSE_O, STRAP_RESERVED_ERR_O;
   logic [31:0] SW_DATA_I = 0, STRAP_CONFIG_PINS_I, setting = 0;
   logic [2:0] PORT_I = 0, MEDIA_SEL_O;
   logic [3:0] ADV_REG4_O, LED_COMBINE_O;
   logic [1:0] ADV_REG9_O, LED_RATE_O;
   logic [7:0] LED_FUNC_O;
   logic [4:0] PHY_ADDR_O;
   int failures = 0, check_count = 0, cyc = 0;
   wire [23:0] got = {DOWNSHIFT_EN_O, ADV_REG4_O, ADV_REG9_O, MAC_ANEG_EN_O,
      LINK_POWER_SAVING_MODE_O, ADV_ASYM_PAUSE_O, ADV_SYM_PAUSE_O, MEDIA_SEL_O,
      MEDIA_RESERVED_O, REFERENCE_CLOCK_OUTPUT_EN_O, LED_RATE_O, ADDR_REVERSE_O, PHY_ADDR_O};
   wire [16:0] got_led = {SIGNAL_DETECT_INPUT_POL_O, REF_CLK_156_O, LED_FIBER_COMBINE_O,
      LED_COMBINE_O, LED_FUNC_O, STRAP_RESERVED_ERR_O, LOADED_O};
   strap_pin_config_loader strap_pin_config_loader_i (.*);
   strap_board strap_board_i (.setting_i(setting), .pins_o(STRAP_CONFIG_PINS_I));
   // Clock and a ceiling well above the few dozen cycles needed
   always #10 MCLK_I = ~MCLK_I;
   always @(posedge MCLK_I) if (++cyc == 400) begin failures++; report_and_stop(); end
   task report_and_stop(); $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("DONE - PASS"); else $display("DONE - FAIL");
      $finish; endtask
   task chk(logic [31:0] g, logic [31:0] e); check_count++;
      if (g !== e) begin failures++; $display("BAD %0t %h %h", $time, g, e); end endtask
   // Straps set under reset, then a bounded wait for the load
   task restart(logic [31:0] s); @(posedge MCLK_I); #2 setting = s; RESET_I = 1;
      repeat (3) @(posedge MCLK_I); #2 RESET_I = 0;
      repeat (20) begin @(posedge MCLK_I); #2 if (LOADED_O === 1'b1) break; end endtask
   // Loaded values must not follow later strap changes
   task hold_test(); restart(32'h5A93_8080); chk(got, {1'b1, strap_cfg_pkg::ADV4_FDX_HDX100,
      strap_cfg_pkg::ADV9_FDX, 4'hA, strap_cfg_pkg::MEDIA_AMS_PASS, 4'h7, 6'h10});
      chk(got_led, 17'h0_0001);
      setting = 32'h0000_0000; repeat (5) @(posedge MCLK_I);
      chk(got, {1'b1, 4'hF, 2'h2, 4'hA, 3'h5, 4'h7, 6'h10}); endtask
   task reserved_test(); restart(32'h2088_8800); chk(got, {1'b0, strap_cfg_pkg::ADV4_NONE,
      strap_cfg_pkg::ADV9_FDX, 4'h0, 3'h7, 4'h8, 6'h27});
      chk(got_led, 17'h0_0001); endtask
   // LED pins, clocking bits and a non-zero port number
   task led_test(); @(posedge MCLK_I); #2 PORT_I = 3'h3; restart(32'h0066_7526);
      chk(got, {1'b0, 4'hF, 2'h3, 4'h0, 3'h0, 4'h2, 6'h03});
      chk(got_led, {1'b1, 1'b1, 1'b1, 4'hD, 8'hDA, 1'b0, 1'b1}); endtask
   // Software overwrite after the load, reserved bit included
   task sw_test(); @(posedge MCLK_I); #2 SW_DATA_I = 32'h8F00_0000; SW_WRITE_I = 1;
      @(posedge MCLK_I); #2 SW_WRITE_I = 0; @(posedge MCLK_I); #2
      chk(got, {1'b0, 4'hF, 2'h3, 4'hF, 3'h0, 4'h0, 6'h03});
      chk(got_led, 17'h0_0003); endtask
   initial begin hold_test(); reserved_test(); led_test(); sw_test(); report_and_stop(); end
endmodule

// [hdl/strap_pin_config_loader.sv]
`timescale 1ns/100ps
// Functional notes
// [RL1] Eight strap pins are read, each giving four configuration bits.
// [RL2] Strap values load the register field defaults, which software may overwrite later.
// [RL3] The board ties bit 3 of strap pin 7 low since it is reserved.
// [RL4] Pin 7 bit 2 sets the link speed downshift enable.
// [RL5] Pin 7 bits 1:0 set the speed and duplex advertisement fields.
// [RL6] Pin 6 sets MAC auto-negotiation, power saving, asymmetric and symmetric pause.
// [RL7] Bit 3 of pins 5..3 gives media select, pin 2 address reversal, pins 1,0 address bits 4:3.
// [RL8] Pin 5 sets signal-detect polarity, reference clock speed and clock output enable.
// [RL9] Pins 3..0 set combine mode and two-bit function for LED3..LED0.
// [RL10] Pin 4 sets fiber/copper LED combine and the LED rate field.
// [RL11] The media field decodes five legal codes and flags the rest as reserved.
// [RL12] The LED rate field picks blink rate and pulse stretch from four steps.
// [RL13] Address reversal maps port n to local address 7-n.
// [RL14] Straps are captured once after reset release and applied before operation.
module strap_pin_config_loader (
   // Clock and reset
   input wire logic MCLK_I,
   input wire logic RESET_I,
   // Strap pins, four bits each, pin 7 highest
   input wire logic [31:0] STRAP_CONFIG_PINS_I,
   // Software overwrite of the loaded defaults
   input wire logic SW_WRITE_I,
   input wire logic [31:0] SW_DATA_I,
   // Port number used for the address mapping
   input wire logic [2:0] PORT_I,
   // Loaded field values
   output logic LOADED_O,
   output logic DOWNSHIFT_EN_O,
   output logic [3:0] ADV_REG4_O,
   output logic [1:0] ADV_REG9_O,
   output logic MAC_ANEG_EN_O,
   output logic LINK_POWER_SAVING_MODE_O,
   output logic ADV_ASYM_PAUSE_O,
   output logic ADV_SYM_PAUSE_O,
   output logic [2:0] MEDIA_SEL_O,
   output logic MEDIA_RESERVED_O,
   output logic SIGNAL_DETECT_INPUT_POL_O,
   output logic REF_CLK_156_O,
   output logic REFERENCE_CLOCK_OUTPUT_EN_O,
   output logic LED_FIBER_COMBINE_O,
   output logic [1:0] LED_RATE_O,
   output logic [3:0] LED_COMBINE_O,
   output logic [7:0] LED_FUNC_O,
   output logic ADDR_REVERSE_O,
   output logic [4:0] PHY_ADDR_O,
   output logic STRAP_RESERVED_ERR_O
);

   // Picks one pin's four configuration bits out of a 32-bit image
   function automatic logic [3:0] strap_nibble(input logic [31:0] img, input int unsigned pin);
      return img[pin * strap_cfg_pkg::BITS_PER_PIN +: strap_cfg_pkg::BITS_PER_PIN];
   endfunction

   // Legal media interface codes; everything else is reserved
   function automatic logic media_is_legal(input logic [2:0] code);
      return code inside {strap_cfg_pkg::MEDIA_COPPER, strap_cfg_pkg::MEDIA_PASSTHRU,
         strap_cfg_pkg::MEDIA_FIBER, strap_cfg_pkg::MEDIA_AMS_PASS,
         strap_cfg_pkg::MEDIA_AMS_FIBER};
   endfunction

   // Speed code to the 10/100 advertisement bits
   function automatic logic [3:0] adv_reg4_of(input logic [1:0] code);
      logic [3:0] val;
      val = strap_cfg_pkg::ADV4_NONE;
      unique case (code)
         2'h0: val = strap_cfg_pkg::ADV4_ALL;
         2'h1: val = strap_cfg_pkg::ADV4_FDX_HDX100;
         2'h2: val = strap_cfg_pkg::ADV4_NONE;
         2'h3: val = strap_cfg_pkg::ADV4_FDX_HDX100;
      endcase
      return val;
   endfunction

   // Speed code to the gigabit advertisement bits
   function automatic logic [1:0] adv_reg9_of(input logic [1:0] code);
      logic [1:0] val;
      val = strap_cfg_pkg::ADV9_NONE;
      unique case (code)
         2'h0: val = strap_cfg_pkg::ADV9_ALL;
         2'h1: val = strap_cfg_pkg::ADV9_FDX;
         2'h2: val = strap_cfg_pkg::ADV9_FDX;
         2'h3: val = strap_cfg_pkg::ADV9_NONE;
      endcase
      return val;
   endfunction

   // Pin synchroniser; kept out of reset so the chain holds the straps at release
   logic [31:0] strap_meta_q;
   logic [31:0] strap_sync_q;

   // Load sequencer
   strap_cfg_pkg::load_state_t state_q;
   strap_cfg_pkg::load_state_t state_d;
   logic [1:0] settle_cnt_q;
   logic [1:0] settle_cnt_d;
   logic load_en;
   logic sw_en;
   logic image_en;
   logic loaded_q;

   // Loaded image, same layout as the strap pins
   logic [31:0] image_q;
   logic [31:0] image_d;
   logic [3:0] nib_d [strap_cfg_pkg::NUM_PINS];
   logic [1:0] speed_code;

   // Decoded next field values
   logic downshift_d;
   logic [3:0] adv4_d;
   logic [1:0] adv9_d;
   logic mac_aneg_d;
   logic power_save_d;
   logic asym_pause_d;
   logic sym_pause_d;
   logic [2:0] media_d;
   logic media_rsv_d;
   logic sd_pol_d;
   logic clk156_d;
   logic reference_clock_output_en_d;
   logic led_fiber_comb_d;
   logic [1:0] led_rate_d;
   logic [3:0] led_comb_d;
   logic [7:0] led_func_d;
   logic addr_rev_d;
   logic [1:0] addr_hi_d;
   logic rsv_err_d;
   logic addr_rev_cur;
   logic [1:0] addr_hi_cur;
   logic [2:0] port_addr;
   logic [4:0] phy_addr_d;

   // Field registers
   logic downshift_q;
   logic [3:0] adv4_q;
   logic [1:0] adv9_q;
   logic mac_aneg_q;
   logic power_save_q;
   logic asym_pause_q;
   logic sym_pause_q;
   logic [2:0] media_q;
   logic media_rsv_q;
   logic sd_pol_q;
   logic clk156_q;
   logic reference_clock_output_en_q;
   logic led_fiber_comb_q;
   logic [1:0] led_rate_q;
   logic [3:0] led_comb_q;
   logic [7:0] led_func_q;
   logic addr_rev_q;
   logic [1:0] addr_hi_q;
   logic rsv_err_q;
   logic [4:0] phy_addr_q;

   // Synchroniser stages; only the second stage is read
   always_ff @(posedge MCLK_I) begin
      strap_meta_q <= STRAP_CONFIG_PINS_I; // RL1
      strap_sync_q <= strap_meta_q;
   end

   // Capture strobe after the settle count; software writes only once loaded
   assign load_en = (state_q == strap_cfg_pkg::ST_SETTLE) &&
      (settle_cnt_q == (strap_cfg_pkg::LOAD_CYCLES - 2'h1)); // RL14
   assign sw_en = (state_q == strap_cfg_pkg::ST_LOADED) && SW_WRITE_I; // RL2
   assign image_en = load_en || sw_en;
   assign image_d = load_en ? strap_sync_q : SW_DATA_I;

   // Sequencer next state; capture happens once per reset
   always_comb begin
      state_d = state_q;
      settle_cnt_d = settle_cnt_q;
      unique case (state_q)
         strap_cfg_pkg::ST_RESET: begin
            state_d = strap_cfg_pkg::ST_SETTLE;
            settle_cnt_d = 2'h0;
         end
         strap_cfg_pkg::ST_SETTLE: begin
            settle_cnt_d = settle_cnt_q + 2'h1;
            if (load_en) begin
               state_d = strap_cfg_pkg::ST_LOADED; // RL14
            end
         end
         strap_cfg_pkg::ST_LOADED: begin
            state_d = strap_cfg_pkg::ST_LOADED;
         end
         default: begin
            state_d = strap_cfg_pkg::ST_RESET;
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge MCLK_I) begin
      if (RESET_I) begin
         state_q <= strap_cfg_pkg::ST_RESET;
         settle_cnt_q <= 2'h0;
         loaded_q <= 1'b0;
      end else begin
         state_q <= state_d;
         settle_cnt_q <= settle_cnt_d;
         loaded_q <= loaded_q || load_en;
      end
   end

   // Image register; later strap changes never reach it
   always_ff @(posedge MCLK_I) begin
      if (RESET_I) begin
         image_q <= strap_cfg_pkg::IMAGE_RESET;
      end else if (image_en) begin
         image_q <= image_d; // RL2
      end
   end

   // Split the image into per-pin nibbles
   for (genvar pin = 0; pin < strap_cfg_pkg::NUM_PINS; pin++) begin : g_pin
      assign nib_d[pin] = strap_nibble(image_d, pin); // RL1
   end

   // Pin 7: reserved bit, downshift and speed advertisement
   assign speed_code = nib_d[strap_cfg_pkg::PIN_SPEED][strap_cfg_pkg::BIT_ONE:
      strap_cfg_pkg::BIT_LSB];
   assign rsv_err_d = nib_d[strap_cfg_pkg::PIN_SPEED][strap_cfg_pkg::BIT_MSB];
   assign downshift_d = nib_d[strap_cfg_pkg::PIN_SPEED][strap_cfg_pkg::BIT_MID]; // RL4
   assign adv4_d = adv_reg4_of(speed_code); // RL5
   assign adv9_d = adv_reg9_of(speed_code); // RL5

   // Pin 6: MAC negotiation, power saving and pause enables
   assign mac_aneg_d = nib_d[strap_cfg_pkg::PIN_MAC][strap_cfg_pkg::BIT_MSB]; // RL6
   assign power_save_d = nib_d[strap_cfg_pkg::PIN_MAC][strap_cfg_pkg::BIT_MID]; // RL6
   assign asym_pause_d = nib_d[strap_cfg_pkg::PIN_MAC][strap_cfg_pkg::BIT_ONE]; // RL6
   assign sym_pause_d = nib_d[strap_cfg_pkg::PIN_MAC][strap_cfg_pkg::BIT_LSB]; // RL6

   // Media select is spread over the top bit of pins 5..3
   assign media_d = {nib_d[strap_cfg_pkg::PIN_CLK][strap_cfg_pkg::BIT_MSB],
      nib_d[strap_cfg_pkg::PIN_LEDRATE][strap_cfg_pkg::BIT_MSB],
      nib_d[strap_cfg_pkg::PIN_LED3][strap_cfg_pkg::BIT_MSB]}; // RL7
   assign media_rsv_d = !media_is_legal(media_d); // RL11

   // Pin 5 clocking and pin 4 LED controls
   assign sd_pol_d = nib_d[strap_cfg_pkg::PIN_CLK][strap_cfg_pkg::BIT_MID]; // RL8
   assign clk156_d = nib_d[strap_cfg_pkg::PIN_CLK][strap_cfg_pkg::BIT_ONE]; // RL8
   assign reference_clock_output_en_d = nib_d[strap_cfg_pkg::PIN_CLK][strap_cfg_pkg::BIT_LSB]; // RL8
   assign led_fiber_comb_d = nib_d[strap_cfg_pkg::PIN_LEDRATE][strap_cfg_pkg::BIT_MID]; // RL10
   // Rate code passed on as is; the LED driver owns the blink timing
   assign led_rate_d = nib_d[strap_cfg_pkg::PIN_LEDRATE][strap_cfg_pkg::BIT_ONE:
      strap_cfg_pkg::BIT_LSB]; // RL10 RL12

   // One LED per lower pin; pin n drives LEDn
   for (genvar led = 0; led < strap_cfg_pkg::NUM_LEDS; led++) begin : g_led
      assign led_comb_d[led] = nib_d[led][strap_cfg_pkg::BIT_MID]; // RL9
      assign led_func_d[led * strap_cfg_pkg::LED_FUNC_BITS +: strap_cfg_pkg::LED_FUNC_BITS] =
         nib_d[led][strap_cfg_pkg::BIT_ONE:strap_cfg_pkg::BIT_LSB]; // RL9
   end

   // Address reversal and high address bits
   assign addr_rev_d = nib_d[strap_cfg_pkg::PIN_ADDR_REV][strap_cfg_pkg::BIT_MSB]; // RL7
   assign addr_hi_d = {nib_d[strap_cfg_pkg::PIN_ADDR4][strap_cfg_pkg::BIT_MSB],
      nib_d[strap_cfg_pkg::PIN_ADDR3][strap_cfg_pkg::BIT_MSB]}; // RL7

   // Use the incoming fields on a load edge so the address is valid with the loaded flag
   assign addr_rev_cur = image_en ? addr_rev_d : addr_rev_q;
   assign addr_hi_cur = image_en ? addr_hi_d : addr_hi_q;
   assign port_addr = addr_rev_cur ? ~PORT_I : PORT_I; // RL13
   assign phy_addr_d = {addr_hi_cur, port_addr}; // RL7

   // Advertisement and enable fields
   always_ff @(posedge MCLK_I) begin
      if (RESET_I) begin
         downshift_q <= 1'b0;
         adv4_q <= 4'h0;
         adv9_q <= 2'h0;
         mac_aneg_q <= 1'b0;
         power_save_q <= 1'b0;
         asym_pause_q <= 1'b0;
         sym_pause_q <= 1'b0;
         rsv_err_q <= 1'b0;
      end else if (image_en) begin
         downshift_q <= downshift_d;
         adv4_q <= adv4_d;
         adv9_q <= adv9_d;
         mac_aneg_q <= mac_aneg_d;
         power_save_q <= power_save_d;
         asym_pause_q <= asym_pause_d;
         sym_pause_q <= sym_pause_d;
         rsv_err_q <= rsv_err_d;
      end
   end

   // Media and clocking fields
   always_ff @(posedge MCLK_I) begin
      if (RESET_I) begin
         media_q <= 3'h0;
         media_rsv_q <= 1'b0;
         sd_pol_q <= 1'b0;
         clk156_q <= 1'b0;
         reference_clock_output_en_q <= 1'b0;
      end else if (image_en) begin
         media_q <= media_d;
         media_rsv_q <= media_rsv_d;
         sd_pol_q <= sd_pol_d;
         clk156_q <= clk156_d;
         reference_clock_output_en_q <= reference_clock_output_en_d;
      end
   end

   // LED fields
   always_ff @(posedge MCLK_I) begin
      if (RESET_I) begin
         led_fiber_comb_q <= 1'b0;
         led_rate_q <= 2'h0;
         led_comb_q <= 4'h0;
         led_func_q <= 8'h00;
      end else if (image_en) begin
         led_fiber_comb_q <= led_fiber_comb_d;
         led_rate_q <= led_rate_d;
         led_comb_q <= led_comb_d;
         led_func_q <= led_func_d;
      end
   end

   // Address fields; the port address follows its input every cycle
   always_ff @(posedge MCLK_I) begin
      if (RESET_I) begin
         addr_rev_q <= 1'b0;
         addr_hi_q <= 2'h0;
         phy_addr_q <= 5'h00;
      end else begin
         phy_addr_q <= phy_addr_d; // RL13
         if (image_en) begin
            addr_rev_q <= addr_rev_d;
            addr_hi_q <= addr_hi_d;
         end
      end
   end

   // Outputs straight from the registers
   assign LOADED_O = loaded_q;
   assign DOWNSHIFT_EN_O = downshift_q;
   assign ADV_REG4_O = adv4_q;
   assign ADV_REG9_O = adv9_q;
   assign MAC_ANEG_EN_O = mac_aneg_q;
   assign LINK_POWER_SAVING_MODE_O = power_save_q;
   assign ADV_ASYM_PAUSE_O = asym_pause_q;
   assign ADV_SYM_PAUSE_O = sym_pause_q;
   assign MEDIA_SEL_O = media_q;
   assign MEDIA_RESERVED_O = media_rsv_q;
   assign SIGNAL_DETECT_INPUT_POL_O = sd_pol_q;
   assign REF_CLK_156_O = clk156_q;
   assign REFERENCE_CLOCK_OUTPUT_EN_O = reference_clock_output_en_q;
   assign LED_FIBER_COMBINE_O = led_fiber_comb_q;
   assign LED_RATE_O = led_rate_q;
   assign LED_COMBINE_O = led_comb_q;
   assign LED_FUNC_O = led_func_q;
   assign ADDR_REVERSE_O = addr_rev_q;
   assign PHY_ADDR_O = phy_addr_q;
   assign STRAP_RESERVED_ERR_O = rsv_err_q;

   // Load sequence checks
   chk_stays_loaded: assert property (@(posedge MCLK_I) disable iff (RESET_I) // RL14
      loaded_q |=> loaded_q)
      else $error("loaded flag dropped without reset");
   chk_load_latency: assert property (@(posedge MCLK_I) disable iff (RESET_I) // RL14
      (state_q == strap_cfg_pkg::ST_RESET) |-> ##3 loaded_q)
      else $error("strap load late after reset release");
   chk_straps_ignored: assert property (@(posedge MCLK_I) disable iff (RESET_I) // RL14
      (loaded_q && !SW_WRITE_I) |=> $stable(image_q))
      else $error("loaded image changed without a write");
   chk_sw_overwrite: assert property (@(posedge MCLK_I) disable iff (RESET_I) // RL2
      sw_en |=> (image_q == $past(SW_DATA_I)))
      else $error("software write not taken");

   // Field checks
   chk_media_flag: assert property (@(posedge MCLK_I) disable iff (RESET_I) // RL11
      loaded_q |-> (MEDIA_RESERVED_O == !(MEDIA_SEL_O inside {3'h0, 3'h1, 3'h2, 3'h5, 3'h6})))
      else $error("media reserved flag wrong");
   chk_adv_gig_only: assert property (@(posedge MCLK_I) disable iff (RESET_I) // RL5
      (loaded_q && (ADV_REG4_O == 4'h0)) |-> (ADV_REG9_O == 2'h2))
      else $error("gigabit-only advertisement wrong");
   chk_phy_addr_map: assert property (@(posedge MCLK_I) disable iff (RESET_I) // RL13
      loaded_q |-> (PHY_ADDR_O == {addr_hi_q,
         (ADDR_REVERSE_O ? ~$past(PORT_I) : $past(PORT_I))}))
      else $error("port address mapping wrong");
   chk_downshift_bit: assert property (@(posedge MCLK_I) disable iff (RESET_I) // RL4
      loaded_q |-> (DOWNSHIFT_EN_O ==
         image_q[strap_cfg_pkg::PIN_SPEED * strap_cfg_pkg::BITS_PER_PIN + strap_cfg_pkg::BIT_MID]))
      else $error("downshift enable wrong");

   // Main scenarios
   cov_sw_write: cover property (@(posedge MCLK_I) disable iff (RESET_I) sw_en);
   cov_media_reserved: cover property (@(posedge MCLK_I) disable iff (RESET_I)
      loaded_q && MEDIA_RESERVED_O);
   cov_addr_reversed: cover property (@(posedge MCLK_I) disable iff (RESET_I)
      loaded_q && ADDR_REVERSE_O);

endmodule
